// File: sar_pkg.sv
// constants shared by the serial converter control logic
package sar_pkg;
	localparam int        RES_BITS     = 14;
	localparam int        CNT_W        = 5;
	localparam int        SYNC_W       = 3;
	localparam int        SYNC_CS      = 0;
	localparam int        SYNC_SCLK    = 1;
	localparam int        SYNC_COMP    = 2;
	localparam int        MCLK_NS      = 25;
	localparam int        FRAME_CYCLES = 18;
	localparam int        CONV_PERIODS = 15;
	localparam int        MSB_INDEX    = 13;
	localparam logic [4:0] EDGE_FIRST  = 5'h01;
	localparam logic [4:0] EDGE_LASTBIT = 5'h0F;
	localparam logic [4:0] EDGE_TRACK  = 5'h10;
	localparam logic [4:0] EDGE_FRAME  = 5'h12;
	localparam logic [4:0] EDGE_BITBASE = 5'h0F;
	localparam logic [13:0] CODE_RESET = 14'h0000;
	localparam logic [13:0] CODE_MID   = 14'h2000;
	localparam logic [13:0] CODE_POS_FS = 14'h1FFF;
	localparam logic [13:0] CODE_NEG_FS = 14'h2000;
	localparam logic [2:0] SYNC_RESET  = 3'h7;
	typedef enum logic [1:0] {
		SAR_IDLE,
		SAR_WAIT,
		SAR_CONV,
		SAR_ACQ
	} sar_state_t;
endpackage

// File: sar_sync.sv
// two-flop synchronisers for the asynchronous pin inputs
`timescale 1ns/100ps
module sar_sync
	import sar_pkg::*;
(
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              resetn_in,
	// raw and synchronised levels
	input  wire logic [SYNC_W-1:0] raw_in,
	output logic      [SYNC_W-1:0] sync_out
);
	logic [SYNC_W-1:0] stage1;

	// chip select idles high and the serial clock idles high after reset
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage1   <= SYNC_RESET;
			sync_out <= SYNC_RESET;
		end else begin
			stage1   <= raw_in;
			sync_out <= stage1;
		end
	end
endmodule

// File: sar_ctrl.sv
// conversion sequencing and serial result readout for the 14-bit converter
`timescale 1ns/100ps
module sar_ctrl
	import sar_pkg::*;
(
	// clock and reset
	input  wire logic                mclk_in,
	input  wire logic                resetn_in,
	// serial pins
	input  wire logic                csn_in,
	input  wire logic                sclk_in,
	output logic                     dout_out,
	output logic                     dout_oe_out,
	// analog array
	input  wire logic                comp_in,
	output logic      [RES_BITS-1:0] dac_code_out,
	output logic                     track_out,
	output logic                     converting_out
);
	logic [SYNC_W-1:0] sync_lvl;
	logic              csn_s;
	logic              sclk_s;
	logic              comp_s;
	logic              csn_prev;
	logic              sclk_prev;
	sar_state_t        state;
	sar_state_t        next_state;
	logic [CNT_W-1:0]  edge_cnt;
	logic [CNT_W-1:0]  next_cnt;
	logic [RES_BITS-1:0] sar_code;

	// bit decided on a given falling edge: edge 2 decides bit 13
	function automatic logic [3:0] bit_of_edge(input logic [CNT_W-1:0] e);
		logic [CNT_W-1:0] d;
		d = EDGE_BITBASE - e;
		return d[3:0];
	endfunction

	sar_sync u_sync (
		.mclk_in  (mclk_in),
		.resetn_in(resetn_in),
		.raw_in   ({comp_in, sclk_in, csn_in}),
		.sync_out (sync_lvl)
	);

	assign csn_s  = sync_lvl[SYNC_CS];
	assign sclk_s = sync_lvl[SYNC_SCLK];
	assign comp_s = sync_lvl[SYNC_COMP];

	// edges are taken from the second synchroniser stage only
	wire       cs_fall   = csn_prev & ~csn_s;
	wire       cs_rise   = ~csn_prev & csn_s;
	wire       sclk_fall = sclk_prev & ~sclk_s;
	wire       conv_edge = (state == SAR_CONV) && sclk_fall && !cs_rise;
	wire [3:0] dec_idx   = bit_of_edge(next_cnt);
	wire       decide    = conv_edge && (next_cnt > EDGE_FIRST) && (next_cnt <= EDGE_LASTBIT);
	// offset-binary search, msb flipped on the way out for two's complement
	wire       out_bit   = (dec_idx == 4'(MSB_INDEX)) ? ~comp_s : comp_s;
	wire       track_hit = conv_edge && (next_cnt == EDGE_TRACK);

	assign next_cnt = edge_cnt + 5'h01;

	always_comb begin
		next_state = state;
		if (cs_rise) begin
			next_state = SAR_IDLE;
		end else if (cs_fall) begin
			// chip select falling with the clock low counts as the first edge
			next_state = sclk_s ? SAR_WAIT : SAR_CONV;
		end else begin
			unique case (state)
				SAR_IDLE: next_state = SAR_IDLE;
				SAR_WAIT: next_state = sclk_fall ? SAR_CONV : SAR_WAIT;
				SAR_CONV: next_state = track_hit ? SAR_ACQ : SAR_CONV;
				SAR_ACQ:  next_state = SAR_ACQ;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			csn_prev  <= 1'b1;
			sclk_prev <= 1'b1;
			state     <= SAR_IDLE;
		end else begin
			csn_prev  <= csn_s;
			sclk_prev <= sclk_s;
			state     <= next_state;
		end
	end

	// edge counter runs through the whole frame and stops at its length
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			edge_cnt <= '0;
		end else if (cs_rise) begin
			edge_cnt <= '0;
		end else if (cs_fall) begin
			edge_cnt <= sclk_s ? 5'h00 : EDGE_FIRST;
		end else if (sclk_fall && (state != SAR_IDLE) && (edge_cnt < EDGE_FRAME)) begin
			edge_cnt <= next_cnt;
		end
	end

	// successive approximation: keep or drop the trial bit, set the next one
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sar_code <= CODE_RESET;
		end else if ((cs_fall && !sclk_s) || ((state == SAR_WAIT) && sclk_fall && !cs_rise)) begin
			sar_code <= CODE_MID;
		end else if (decide) begin
			sar_code[dec_idx] <= comp_s;
			if (dec_idx != 4'h0) begin
				sar_code[dec_idx - 4'h1] <= 1'b1;
			end
		end
	end

	// each decided bit goes out on the same edge it is decided
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dout_out    <= 1'b0;
			dout_oe_out <= 1'b0;
		end else begin
			dout_oe_out <= ~csn_s;
			if (cs_fall || cs_rise || track_hit) begin
				dout_out <= 1'b0;
			end else if (decide) begin
				dout_out <= out_bit;
			end
		end
	end

	assign dac_code_out   = sar_code;
	// switches stay open for the whole conversion
	assign converting_out = (state == SAR_CONV);
	assign track_out      = (state != SAR_CONV);

	oe_off_high_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		csn_s |=> !dout_oe_out) else $error("output enabled with chip select high");

	short_cycle_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		cs_rise |=> (state == SAR_IDLE) && track_out && (edge_cnt == 5'h00))
		else $error("conversion not abandoned on chip select rise");

	track_after16_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		conv_edge && (edge_cnt == EDGE_LASTBIT) |=> (state == SAR_ACQ) && track_out && !dout_out)
		else $error("no tracking after sixteenth falling edge");

	hold_in_conv_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		converting_out && !cs_rise && !track_hit |=> converting_out && !track_out)
		else $error("input reconnected during conversion");

	msb_first_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		conv_edge && (edge_cnt == EDGE_FIRST) |=> dout_out == !$past(comp_s))
		else $error("first result bit is not the inverted msb decision");

	lsb_last_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		conv_edge && (edge_cnt == 5'h0E) |=> dout_out == $past(comp_s) && sar_code[0] == $past(comp_s))
		else $error("last bit does not match the stored code");

	fresh_start_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(state == SAR_WAIT) && sclk_fall && !cs_rise |=> (sar_code == CODE_MID) && (edge_cnt == EDGE_FIRST))
		else $error("conversion did not start from a fresh code");

	conv_window_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		converting_out |-> (edge_cnt >= EDGE_FIRST) && (edge_cnt <= EDGE_LASTBIT))
		else $error("converting outside the first fifteen periods");

	first_edge_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(state == SAR_WAIT) && !sclk_fall && !cs_rise |=> (state == SAR_WAIT) && (edge_cnt == 5'h00))
		else $error("conversion started without a falling serial clock");

	acq_quiet_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(state == SAR_ACQ) |-> !dout_out && (edge_cnt >= EDGE_TRACK) && (edge_cnt <= EDGE_FRAME))
		else $error("acquisition state out of frame bounds");

	lead_zero_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		converting_out && (edge_cnt == EDGE_FIRST) |-> !dout_out)
		else $error("lead period shows a data bit");

	bit_stands_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		converting_out && !sclk_fall && !cs_rise |=> $stable(dout_out))
		else $error("serial bit changed between clock falls");

	code_hold_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		converting_out && !sclk_fall |=> $stable(sar_code))
		else $error("trial code moved without a clock fall");

	frame_cap_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(edge_cnt == EDGE_FRAME) && !cs_rise |=> (edge_cnt == EDGE_FRAME))
		else $error("falls beyond the frame length were counted");

	acq_hold_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(state == SAR_ACQ) && !cs_rise |=> (state == SAR_ACQ) && track_out && !converting_out)
		else $error("tracking left before chip select rose");

	idle_quiet_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(state == SAR_IDLE) |-> !dout_out && track_out && !converting_out)
		else $error("activity outside a frame");

	idle_no_count_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(state == SAR_IDLE) && !cs_fall |=> (state == SAR_IDLE) && (edge_cnt == 5'h00))
		else $error("frame started without chip select falling");

	oe_on_low_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		!csn_s |=> dout_oe_out)
		else $error("output not driven with chip select low");

	low_start_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		cs_fall && !sclk_s |=> converting_out && (sar_code == CODE_MID) && (edge_cnt == EDGE_FIRST))
		else $error("select fall with clock low did not count as first edge");
endmodule

// File: sar_host.sv
// controller and analog array stand-in for the converter
`timescale 1ns/100ps
module sar_host
	import sar_pkg::*;
(
	// clock
	input  wire logic                mclk_in,
	// device side
	input  wire logic                dout_in,
	input  wire logic                dout_oe_in,
	input  wire logic [RES_BITS-1:0] dac_code_in,
	input  wire logic                converting_in,
	// driven pins
	output logic                     csn_out,
	output logic                     sclk_out,
	output logic                     comp_out
);
	logic [RES_BITS-1:0] level;
	logic                last = 1'b0;
	logic                line;
	logic [18:1]         conv_hist;
	logic [18:1]         oe_hist;
	assign comp_out = (level >= dac_code_in);
	// a released pin must not look like a held bit
	assign line = dout_oe_in ? dout_in : ~last;
	always_ff @(posedge mclk_in) begin
		if (dout_oe_in)
			last <= dout_in;
	end
	initial begin
		csn_out = 1'b1;
		sclk_out = 1'b1;
		level = CODE_MID;
	end
	task automatic half();
		repeat (8) @(negedge mclk_in);
	endtask
	// n falls; lowstart drops select with the clock already low
	task automatic frame(input logic [RES_BITS-1:0] lvl, input int n, input bit lowstart,
			output logic [RES_BITS-1:0] got);
		level = lvl;
		got = '0;
		conv_hist = '0;
		oe_hist = '0;
		sclk_out = !lowstart;
		half();
		csn_out = 1'b0;
		half();
		for (int k = 1; k <= n; k++) begin
			sclk_out = 1'b0;
			half();
			if (k >= 2 && k <= 15)
				got[15-k] = line;
			if (k <= 18) begin
				conv_hist[k] = converting_in;
				oe_hist[k] = dout_oe_in;
			end
			sclk_out = 1'b1;
			half();
		end
		csn_out = 1'b1;
		half();
		half();
	endtask
endmodule

// File: testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
	import sar_pkg::*;
	logic                mclk_in;
	logic                resetn_in;
	logic                csn;
	logic                sclk;
	logic                comp;
	logic                dout;
	logic                dout_oe;
	logic                track;
	logic                conv;
	logic [RES_BITS-1:0] dac_code;
	logic [RES_BITS-1:0] got;
	int                  fails;
	int                  checks_done;
	sar_ctrl u_dut(.mclk_in(mclk_in), .resetn_in(resetn_in), .csn_in(csn), .sclk_in(sclk),
		.dout_out(dout), .dout_oe_out(dout_oe), .comp_in(comp), .dac_code_out(dac_code),
		.track_out(track), .converting_out(conv));
	sar_host u_host(.mclk_in(mclk_in), .dout_in(dout), .dout_oe_in(dout_oe),
		.dac_code_in(dac_code), .converting_in(conv), .csn_out(csn), .sclk_out(sclk),
		.comp_out(comp));
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// full scale both ways and back-to-back unlike codes
	task automatic test_codes();
		logic [RES_BITS-1:0] lv [5] = '{14'h3FFF, 14'h0000, 14'h2000, 14'h1555, 14'h2AAA};
		for (int i = 0; i < 5; i++) begin
			u_host.frame(lv[i], 18, 1'b0, got);
			check(18'(got), 18'(lv[i] ^ CODE_MID));
			check(18'(dac_code), 18'(lv[i]));
			check(u_host.conv_hist, 18'h07FFF);
			check(u_host.oe_hist, 18'h3FFFF);
		end
		check({16'h0000, dout_oe, track}, 18'h00001);
	endtask
	// abandon after 6 falls, then a clean frame started with the clock low
	task automatic test_short();
		u_host.frame(14'h3A5C, 6, 1'b0, got);
		check(18'(got), 18'h01A00);
		check({16'h0000, conv, track}, 18'h00001);
		u_host.frame(14'h0F0F, 18, 1'b1, got);
		check(18'(got), 18'h02F0F);
	endtask
	// surplus falls after the frame must not restart a conversion
	task automatic test_long();
		u_host.frame(14'h2001, 22, 1'b0, got);
		check(18'(got), 18'h00001);
		check(u_host.conv_hist, 18'h07FFF);
	endtask
	initial begin
		repeat (20000) @(posedge mclk_in);
		fails++;
		stop_test();
	end
	initial begin
		resetn_in = 1'b0;
		fails = 0;
		checks_done = 0;
		repeat (10) @(negedge mclk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		test_codes();
		test_short();
		test_long();
		stop_test();
	end
endmodule
